// *** design/dmc_pkg.sv ***
/*
  Constants, types and helper functions for the mode-control register bank
  of a dual-channel interpolating converter.
  Assumes it is compiled before every design file that refers to it.
*/
`default_nettype none

package dmc_pkg;

  // ----------------------------------------------------------------------
  // Register addresses
  // ----------------------------------------------------------------------
  localparam int NUM_REGS = 14;
  localparam logic [4:0] A_PORT = 5'h00;
  localparam logic [4:0] A_FILTER = 5'h01;
  localparam logic [4:0] A_FORMAT = 5'h02;
  localparam logic [4:0] A_CLKDIV = 5'h03;
  localparam logic [4:0] A_LOOP = 5'h04;
  localparam logic [4:0] A_I_FINE = 5'h05;
  localparam logic [4:0] A_I_COARSE = 5'h06;
  localparam logic [4:0] A_I_OFFHI = 5'h07;
  localparam logic [4:0] A_I_OFFLO = 5'h08;
  localparam logic [4:0] A_Q_FINE = 5'h09;
  localparam logic [4:0] A_Q_COARSE = 5'h0A;
  localparam logic [4:0] A_Q_OFFHI = 5'h0B;
  localparam logic [4:0] A_Q_OFFLO = 5'h0C;
  localparam logic [4:0] A_VER = 5'h0D;

  // ----------------------------------------------------------------------
  // Reset values and storage masks (mask bit clear: not stored, reads 0, save the lock bit of 00h and the version in 0Dh)
  // ----------------------------------------------------------------------
  localparam logic [7:0] RST_FILTER = 8'h04;
  localparam logic [7:0] RST_ZERO = 8'h00;
  localparam logic [7:0] M_PORT = 8'hDC;
  localparam logic [7:0] M_FULL = 8'hFF;
  localparam logic [7:0] M_FORMAT = 8'hF7;
  localparam logic [7:0] M_CLKDIV = 8'h83;
  localparam logic [7:0] M_LOOP = 8'hC7;
  localparam logic [7:0] M_COARSE = 8'h0F;
  localparam logic [7:0] M_OFFLO = 8'h83;
  localparam logic [7:0] M_NONE = 8'h00;

  // ----------------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------------
  localparam int P_SDIO_BIDIR = 7;
  localparam int P_LSB_FIRST = 6;
  localparam int P_SOFT_RESET = 5;
  localparam int P_SLEEP = 4;
  localparam int P_PDOWN = 3;
  localparam int P_ONE_RES = 2;
  localparam int P_LOCK = 1;
  localparam int P_INTERP = 6;
  localparam int P_MOD = 4;
  localparam int P_ZSTUFF = 3;
  localparam int P_REAL_MIX = 2;
  localparam int P_ROTATION = 1;
  localparam int P_PIN_SEL = 0;
  localparam int P_UNSIGNED = 7;
  localparam int P_ONE_PORT = 6;
  localparam int P_STRONG = 5;
  localparam int P_CLK_INV = 4;
  localparam int P_PCLK_INV = 2;
  localparam int P_SEL_INV = 1;
  localparam int P_Q_FIRST = 0;
  localparam int P_RATE_SDO = 7;
  localparam int P_DIV = 0;
  localparam int P_PLL_ON = 7;
  localparam int P_CP_MAN = 6;
  localparam int P_CP = 0;
  localparam int P_OFF_DIR = 7;
  localparam int P_OFF_LO = 0;
  localparam int P_RW = 7;

  // ----------------------------------------------------------------------
  // Serial framing and synchroniser layout
  // ----------------------------------------------------------------------
  localparam logic [2:0] LAST_BIT = 3'h7;
  localparam logic [2:0] CNT_STEP = 3'h1;
  localparam int S_SCLK = 0;
  localparam int S_CS_N = 1;
  localparam int S_SDIO = 2;
  localparam int S_LOCK = 3;
  localparam logic [3:0] SYNC_IDLE = 4'h2;

  // ----------------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------------
  typedef enum logic [1:0] {INTERP_1X, INTERP_2X, INTERP_4X, INTERP_8X} dmc_interp_t;
  typedef enum logic [1:0] {MOD_NONE, MOD_HALF, MOD_QUARTER, MOD_EIGHTH} dmc_mod_t;

  // Decoded mode settings handed to the data path and clock logic.
  typedef struct packed {
    logic sdio_bidir;
    logic lsb_first;
    logic sleep;
    logic power_down;
    logic one_resistor;
    dmc_interp_t interp;
    dmc_mod_t modulation;
    logic zero_stuff;
    logic real_mix;
    logic pos_rotation;
    logic clk_on_shared_pin;
    logic unsigned_data;
    logic one_port;
    logic clk_strong;
    logic clk_invert;
    logic port_clk_invert;
    logic sel_invert;
    logic q_first;
    logic rate_clk_on_sdo;
    logic [1:0] pll_div;
    logic pll_on;
    logic cp_manual;
    logic [2:0] cp_current;
  } dmc_mode_t;

  // Per-channel gain and offset settings.
  typedef struct packed {
    logic [7:0] fine_gain;
    logic [3:0] coarse_gain;
    logic [9:0] offset;
    logic offset_on_comp;
  } dmc_chan_t;

  // ----------------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------------
  // Bits that a register really stores; also masks read-back.
  function automatic logic [7:0] reg_mask(input logic [4:0] a);
    case (a)
      A_PORT: reg_mask = M_PORT;
      A_FORMAT: reg_mask = M_FORMAT;
      A_CLKDIV: reg_mask = M_CLKDIV;
      A_LOOP: reg_mask = M_LOOP;
      A_I_COARSE, A_Q_COARSE: reg_mask = M_COARSE;
      A_I_OFFLO, A_Q_OFFLO: reg_mask = M_OFFLO;
      A_FILTER, A_I_FINE, A_I_OFFHI, A_Q_FINE, A_Q_OFFHI: reg_mask = M_FULL;
      default: reg_mask = M_NONE;
    endcase
  endfunction

  // Default content of a register.
  function automatic logic [7:0] reg_default(input logic [4:0] a);
    reg_default = (a == A_FILTER) ? RST_FILTER : RST_ZERO;
  endfunction

  // One serial bit into a byte, in the selected order.
  function automatic logic [7:0] shift_in(input logic [7:0] sh, input logic b, input logic lsb);
    shift_in = lsb ? {b, sh[7:1]} : {sh[6:0], b};
  endfunction

endpackage

`default_nettype wire

// *** design/dmc_regs.sv ***
/*
  Serial-port slave and mode-control register bank of a dual converter.
  Assumes the serial clock and chip select come from an outside host and
  are far slower than clk_i; rate_clk_i comes from logic on clk_i.
*/
`default_nettype none

module dmc_regs #(
  // Version code; the value is arbitrary.
  parameter logic [3:0] VERSION = 4'h1
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic srst_i,
  // Serial port
  input wire logic spi_sclk_i,
  input wire logic spi_cs_n_i,
  input wire logic spi_sdio_i,
  output logic spi_sdio_o,
  output logic spi_sdio_oe_n_o,
  output logic spi_sdo_o,
  output logic spi_sdo_oe_n_o,
  // Device status and clock
  input wire logic pll_lock_i,
  input wire logic rate_clk_i,
  // Decoded settings
  output dmc_pkg::dmc_mode_t mode_o,
  output dmc_pkg::dmc_chan_t chan_i_o,
  output dmc_pkg::dmc_chan_t chan_q_o,
  output logic restart_o,
  output logic shared_pin_o
);

  // ----------------------------------------------------------------------
  // Input synchronisation
  // ----------------------------------------------------------------------
  typedef enum logic [1:0] {ST_IDLE, ST_INSTR, ST_DATA, ST_DONE} dmc_spi_state_t;

  logic [3:0] pins_s;  // Synchronised pins.
  logic sclk_q;  // Previous serial clock level.
  logic sclk_rise;  // Serial clock rose.
  logic sclk_fall;  // Serial clock fell.

  dmc_sync u_sync (
    .clk_i(clk_i),
    .srst_i(srst_i),
    .async_i({pll_lock_i, spi_sdio_i, spi_cs_n_i, spi_sclk_i}),
    .sync_o(pins_s)
  );

  assign sclk_rise = pins_s[dmc_pkg::S_SCLK] & ~sclk_q;
  assign sclk_fall = ~pins_s[dmc_pkg::S_SCLK] & sclk_q;

  // ----------------------------------------------------------------------
  // State
  // ----------------------------------------------------------------------
  logic [7:0] regs [dmc_pkg::NUM_REGS];  // Register storage.
  logic [7:0] next_regs [dmc_pkg::NUM_REGS];
  dmc_spi_state_t state;  // Serial frame state.
  dmc_spi_state_t next_state;
  logic [2:0] cnt;  // Bits seen in the current byte.
  logic [2:0] next_cnt;
  logic [7:0] sh_in;  // Incoming byte.
  logic [7:0] next_sh_in;
  logic [7:0] sh_out;  // Outgoing read byte.
  logic [7:0] next_sh_out;
  logic rd;  // Frame is a read.
  logic next_rd;
  logic [4:0] addr;  // Frame address.
  logic [4:0] next_addr;
  logic [7:0] sin;  // Byte including the bit now sampled.
  logic wr_stb;  // Write completes this cycle.
  logic next_restart;
  logic next_shared;
  logic out_bit;  // Bit presented to the host.
  logic reading;  // Read data phase.

  // Read value of one address; unmapped space reads zero.
  function automatic logic [7:0] reg_read(input logic [4:0] a);
    logic [7:0] v;
    v = 8'h00;
    if (a < dmc_pkg::A_VER) begin
      v = regs[a[3:0]] & dmc_pkg::reg_mask(a);
      if (a == dmc_pkg::A_PORT) begin
        v[dmc_pkg::P_LOCK] = pins_s[dmc_pkg::S_LOCK];
      end
    end else if (a == dmc_pkg::A_VER) begin
      v = {4'h0, VERSION};
    end
    return v;
  endfunction

  // Channel settings from its four registers.
  function automatic dmc_pkg::dmc_chan_t to_chan(input logic [7:0] fine, input logic [7:0] coarse,
                                                  input logic [7:0] hi, input logic [7:0] lo);
    dmc_pkg::dmc_chan_t c;
    c.fine_gain = fine;
    c.coarse_gain = coarse[3:0];
    c.offset = {hi, lo[dmc_pkg::P_OFF_LO +: 2]};
    c.offset_on_comp = lo[dmc_pkg::P_OFF_DIR];
    return c;
  endfunction

  // ----------------------------------------------------------------------
  // Serial frame: instruction byte, then one data byte
  // ----------------------------------------------------------------------
  assign sin = dmc_pkg::shift_in(sh_in, pins_s[dmc_pkg::S_SDIO], mode_o.lsb_first);

  // Bits are sampled on rising edges and read data moves on falling edges.
  // The first falling edge after the instruction does not shift, so the
  // first data bit is already out before the host samples it.
  always_comb begin
    next_state = state;
    next_cnt = cnt;
    next_sh_in = sh_in;
    next_sh_out = sh_out;
    next_rd = rd;
    next_addr = addr;
    wr_stb = 1'b0;
    if (pins_s[dmc_pkg::S_CS_N]) begin
      // Deselect aborts any frame.
      next_state = ST_IDLE;
      next_cnt = 3'h0;
    end else begin
      case (state)
        ST_IDLE: begin
          next_state = ST_INSTR;
        end
        ST_INSTR: begin
          if (sclk_rise) begin
            next_sh_in = sin;
            next_cnt = cnt + dmc_pkg::CNT_STEP;
            if (cnt == dmc_pkg::LAST_BIT) begin
              next_rd = sin[dmc_pkg::P_RW];
              next_addr = sin[4:0];
              next_sh_out = reg_read(sin[4:0]);
              next_state = ST_DATA;
            end
          end
        end
        ST_DATA: begin
          if (sclk_rise) begin
            next_sh_in = sin;
            next_cnt = cnt + dmc_pkg::CNT_STEP;
            if (cnt == dmc_pkg::LAST_BIT) begin
              wr_stb = ~rd;
              next_state = ST_DONE;
            end
          end else if (sclk_fall && cnt != 3'h0) begin
            next_sh_out = mode_o.lsb_first ? {1'b0, sh_out[7:1]} : {sh_out[6:0], 1'b0};
          end
        end
        ST_DONE: begin
          // Extra clocks are ignored until deselect.
          next_state = ST_DONE;
        end
        default: begin
          next_state = ST_IDLE;
        end
      endcase
    end
  end

  // Serial registers.
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      state <= ST_IDLE;
      cnt <= 3'h0;
      sh_in <= 8'h00;
      sh_out <= 8'h00;
      rd <= 1'b0;
      addr <= 5'h00;
      sclk_q <= 1'b0;
    end else begin
      state <= next_state;
      cnt <= next_cnt;
      sh_in <= next_sh_in;
      sh_out <= next_sh_out;
      rd <= next_rd;
      addr <= next_addr;
      sclk_q <= pins_s[dmc_pkg::S_SCLK];
    end
  end

  // Read data goes out on the data pin only when it is set bidirectional,
  // otherwise on the separate output pin.
  assign reading = (state == ST_DATA) && rd;
  assign out_bit = mode_o.lsb_first ? sh_out[0] : sh_out[7];
  assign spi_sdio_o = out_bit;
  assign spi_sdo_o = out_bit;
  assign spi_sdio_oe_n_o = ~(reading & mode_o.sdio_bidir);
  assign spi_sdo_oe_n_o = ~(reading & ~mode_o.sdio_bidir);

  // ----------------------------------------------------------------------
  // Register file
  // ----------------------------------------------------------------------
  always_comb begin
    next_regs = regs;
    next_restart = 1'b0;
    if (wr_stb && addr <= dmc_pkg::A_VER) begin
      if (addr == dmc_pkg::A_PORT && sin[dmc_pkg::P_SOFT_RESET]) begin
        for (int i = 1; i < dmc_pkg::NUM_REGS; i++) begin
          next_regs[i] = dmc_pkg::reg_default(5'(i));
        end
        next_restart = 1'b1;
      end
      next_regs[addr[3:0]] = sin & dmc_pkg::reg_mask(addr);
    end
    next_shared = regs[dmc_pkg::A_FILTER[3:0]][dmc_pkg::P_PIN_SEL] ?
                  (rate_clk_i ^ regs[dmc_pkg::A_FORMAT[3:0]][dmc_pkg::P_CLK_INV]) : pins_s[dmc_pkg::S_LOCK];
  end

  // Registers only; the reset pin clears 00h as well.
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      for (int i = 0; i < dmc_pkg::NUM_REGS; i++) begin
        regs[i] <= dmc_pkg::reg_default(5'(i));
      end
      restart_o <= 1'b0;
      shared_pin_o <= 1'b0;
    end else begin
      regs <= next_regs;
      restart_o <= next_restart;
      shared_pin_o <= next_shared;
    end
  end

  // ----------------------------------------------------------------------
  // Decoded settings
  // ----------------------------------------------------------------------
  always_comb begin
    mode_o.sdio_bidir = regs[dmc_pkg::A_PORT[3:0]][dmc_pkg::P_SDIO_BIDIR];
    mode_o.lsb_first = regs[dmc_pkg::A_PORT[3:0]][dmc_pkg::P_LSB_FIRST];
    mode_o.sleep = regs[dmc_pkg::A_PORT[3:0]][dmc_pkg::P_SLEEP];
    mode_o.power_down = regs[dmc_pkg::A_PORT[3:0]][dmc_pkg::P_PDOWN];
    mode_o.one_resistor = regs[dmc_pkg::A_PORT[3:0]][dmc_pkg::P_ONE_RES];
    mode_o.interp = dmc_pkg::dmc_interp_t'(regs[dmc_pkg::A_FILTER[3:0]][dmc_pkg::P_INTERP +: 2]);
    mode_o.modulation = dmc_pkg::dmc_mod_t'(regs[dmc_pkg::A_FILTER[3:0]][dmc_pkg::P_MOD +: 2]);
    mode_o.zero_stuff = regs[dmc_pkg::A_FILTER[3:0]][dmc_pkg::P_ZSTUFF];
    mode_o.real_mix = regs[dmc_pkg::A_FILTER[3:0]][dmc_pkg::P_REAL_MIX];
    mode_o.pos_rotation = regs[dmc_pkg::A_FILTER[3:0]][dmc_pkg::P_ROTATION];
    mode_o.clk_on_shared_pin = regs[dmc_pkg::A_FILTER[3:0]][dmc_pkg::P_PIN_SEL];
    mode_o.unsigned_data = regs[dmc_pkg::A_FORMAT[3:0]][dmc_pkg::P_UNSIGNED];
    mode_o.one_port = regs[dmc_pkg::A_FORMAT[3:0]][dmc_pkg::P_ONE_PORT];
    mode_o.clk_strong = regs[dmc_pkg::A_FORMAT[3:0]][dmc_pkg::P_STRONG];
    mode_o.clk_invert = regs[dmc_pkg::A_FORMAT[3:0]][dmc_pkg::P_CLK_INV];
    mode_o.port_clk_invert = regs[dmc_pkg::A_FORMAT[3:0]][dmc_pkg::P_PCLK_INV];
    mode_o.sel_invert = regs[dmc_pkg::A_FORMAT[3:0]][dmc_pkg::P_SEL_INV];
    mode_o.q_first = regs[dmc_pkg::A_FORMAT[3:0]][dmc_pkg::P_Q_FIRST];
    mode_o.rate_clk_on_sdo = regs[dmc_pkg::A_CLKDIV[3:0]][dmc_pkg::P_RATE_SDO];
    mode_o.pll_div = regs[dmc_pkg::A_CLKDIV[3:0]][dmc_pkg::P_DIV +: 2];
    mode_o.pll_on = regs[dmc_pkg::A_LOOP[3:0]][dmc_pkg::P_PLL_ON];
    mode_o.cp_manual = regs[dmc_pkg::A_LOOP[3:0]][dmc_pkg::P_CP_MAN];
    mode_o.cp_current = regs[dmc_pkg::A_LOOP[3:0]][dmc_pkg::P_CP +: 3];
  end

  assign chan_i_o = to_chan(regs[dmc_pkg::A_I_FINE[3:0]], regs[dmc_pkg::A_I_COARSE[3:0]],
                            regs[dmc_pkg::A_I_OFFHI[3:0]], regs[dmc_pkg::A_I_OFFLO[3:0]]);
  assign chan_q_o = to_chan(regs[dmc_pkg::A_Q_FINE[3:0]], regs[dmc_pkg::A_Q_COARSE[3:0]],
                            regs[dmc_pkg::A_Q_OFFHI[3:0]], regs[dmc_pkg::A_Q_OFFLO[3:0]]);

  // ----------------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------------
  logic instr_done;
  assign instr_done = (state == ST_INSTR) && sclk_rise && (cnt == dmc_pkg::LAST_BIT);

  a_unmapped_read: assert property (@(posedge clk_i) disable iff (srst_i)
    instr_done && sin[4:0] > dmc_pkg::A_VER |=> sh_out == 8'h00) else $error("unmapped read not zero");
  a_zero_stuff_bit: assert property (@(posedge clk_i) disable iff (srst_i)
    wr_stb && addr == dmc_pkg::A_FILTER |=> mode_o.zero_stuff == $past(sin[dmc_pkg::P_ZSTUFF]))
    else $error("zero stuffing not taken from write");
  a_shared_pin_mux: assert property (@(posedge clk_i) disable iff (srst_i)
    ##1 shared_pin_o == ($past(mode_o.clk_on_shared_pin) ? $past(rate_clk_i ^ mode_o.clk_invert)
                                                          : $past(pins_s[dmc_pkg::S_LOCK])))
    else $error("shared pin shows wrong source");
  a_i_offset_dir: assert property (@(posedge clk_i) disable iff (srst_i)
    wr_stb && addr == dmc_pkg::A_I_OFFLO |=> chan_i_o.offset_on_comp == $past(sin[dmc_pkg::P_OFF_DIR]))
    else $error("in-phase offset direction wrong");
  a_q_offset_dir: assert property (@(posedge clk_i) disable iff (srst_i)
    wr_stb && addr == dmc_pkg::A_Q_OFFLO |=> chan_q_o.offset_on_comp == $past(sin[dmc_pkg::P_OFF_DIR]))
    else $error("quadrature offset direction wrong");
  a_reset_defaults: assert property (@(posedge clk_i) disable iff (srst_i)
    $fell(srst_i) |-> mode_o.real_mix && mode_o.modulation == dmc_pkg::MOD_NONE && !mode_o.one_port
    && !mode_o.lsb_first && !mode_o.sdio_bidir && !mode_o.unsigned_data && !mode_o.q_first)
    else $error("defaults missing after reset");
  a_soft_reset_eff: assert property (@(posedge clk_i) disable iff (srst_i)
    wr_stb && addr == dmc_pkg::A_PORT && sin[dmc_pkg::P_SOFT_RESET] |=> restart_o
    && regs[dmc_pkg::A_FILTER[3:0]] == dmc_pkg::RST_FILTER && !regs[dmc_pkg::A_PORT[3:0]][dmc_pkg::P_SOFT_RESET]
    && regs[dmc_pkg::A_PORT[3:0]] == ($past(sin) & dmc_pkg::M_PORT)) else $error("soft reset effect wrong");
  a_interp_decode: assert property (@(posedge clk_i) disable iff (srst_i)
    wr_stb && addr == dmc_pkg::A_FILTER |=> mode_o.interp == dmc_pkg::dmc_interp_t'($past(sin[7:6])))
    else $error("interpolation rate wrong");
  a_mod_decode: assert property (@(posedge clk_i) disable iff (srst_i)
    wr_stb && addr == dmc_pkg::A_FILTER |=> mode_o.modulation == dmc_pkg::dmc_mod_t'($past(sin[5:4])))
    else $error("modulation mode wrong");
  a_offset_join: assert property (@(posedge clk_i) disable iff (srst_i)
    wr_stb && addr == dmc_pkg::A_Q_OFFHI |=> chan_q_o.offset[9:2] == $past(sin)) else $error("offset high wrong");
  a_version_ro: assert property (@(posedge clk_i) disable iff (srst_i)
    instr_done && sin[4:0] == dmc_pkg::A_VER |=> sh_out == {4'h0, VERSION}) else $error("version not read-only");

  c_read: cover property (@(posedge clk_i) disable iff (srst_i) reading ##1 state == ST_DONE);
  c_write: cover property (@(posedge clk_i) disable iff (srst_i) wr_stb);
  c_soft_reset: cover property (@(posedge clk_i) disable iff (srst_i) restart_o);
  c_lsb_read: cover property (@(posedge clk_i) disable iff (srst_i) reading && mode_o.lsb_first);

endmodule

`default_nettype wire

// *** design/dmc_sync.sv ***
/*
  Three-stage input synchroniser with a stability filter.
  Assumes its inputs are asynchronous to clk_i; an output bit follows only
  once the second and third stages agree.
*/
`default_nettype none

module dmc_sync (
  // Clock and reset
  input wire logic clk_i,
  input wire logic srst_i,
  // Pins
  input wire logic [3:0] async_i,
  output logic [3:0] sync_o
);

  // Stage registers; stage one feeds stage two only.
  logic [3:0] stage1;
  logic [3:0] stage2;
  logic [3:0] stage3;
  logic [3:0] next_sync;

  // A bit is taken once the two later stages agree, which masks a single
  // metastable resolution from the logic downstream.
  always_comb begin
    next_sync = sync_o;
    for (int i = 0; i < 4; i++) begin
      if (stage2[i] == stage3[i]) begin
        next_sync[i] = stage3[i];
      end
    end
  end

  // Registers only.
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      stage1 <= dmc_pkg::SYNC_IDLE;
      stage2 <= dmc_pkg::SYNC_IDLE;
      stage3 <= dmc_pkg::SYNC_IDLE;
      sync_o <= dmc_pkg::SYNC_IDLE;
    end else begin
      stage1 <= async_i;
      stage2 <= stage1;
      stage3 <= stage2;
      sync_o <= next_sync;
    end
  end

endmodule

`default_nettype wire

// *** testbench/dmc_spi_host.sv ***
/*
  Serial host model: sends one instruction byte and one data byte a frame.
  Assumes clk_i is the device clock; sclk is four clk_i cycles per half.
*/
`default_nettype none

module dmc_spi_host (
  // Clock and returned read bit
  input wire logic clk_i,
  input wire logic rd_i,
  // Serial pins
  output logic sclk_o,
  output logic cs_n_o,
  output logic sdio_o
);
  timeunit 1ns;
  timeprecision 1ns;

  // Idle: clock still and low, select high.
  initial begin
    sclk_o = 1'b0;
    cs_n_o = 1'b1;
    sdio_o = 1'b0;
  end

  task automatic half();
    repeat (4) @(posedge clk_i);
  endtask

  task automatic xfer(input logic [7:0] ins, input logic [7:0] dat, input logic lsb, output logic [7:0] rd);
    logic [15:0] fr;
    int p;
    fr = {ins, dat};
    rd = 8'h00;
    @(posedge clk_i);
    cs_n_o <= 1'b0;
    for (int i = 0; i < 16; i++) begin
      p = (i < 8 ? 8 : 0) + (lsb ? i % 8 : 7 - i % 8);
      // A released data line toggles so a stale value is never read back.
      sdio_o <= (ins[7] && i > 7) ? ~sdio_o : fr[p];
      half();
      sclk_o <= 1'b1;
      repeat (3) @(posedge clk_i);
      // Sampled off the edge, since the device bit lags the host fall.
      @(negedge clk_i);
      if (i > 7) begin
        rd[p] = rd_i;
      end
      @(posedge clk_i);
      sclk_o <= 1'b0;
    end
    half();
    cs_n_o <= 1'b1;
    repeat (10) @(posedge clk_i);
  endtask
endmodule

`default_nettype wire

// *** testbench/dual_dac_mode_control_regs_tb_top.sv ***
/*
  Self-checking bench for the mode-control register bank.
  Assumes the host model drives the serial pins and the bench the rest.
*/
`default_nettype none

module dual_dac_mode_control_regs_tb_top;
  timeunit 1ns;
  timeprecision 1ns;

  // Version code; the value is arbitrary.
  localparam logic [3:0] VER = 4'h6;
  logic clk_i = 1'b0;
  logic srst_i = 1'b1;
  logic pll_lock_i = 1'b0;
  logic rate_clk_i = 1'b0;
  logic spi_sclk_i, spi_cs_n_i, spi_sdio_i, h_sdio, rd_bit, lsb = 1'b0;
  logic spi_sdio_o, spi_sdio_oe_n_o, spi_sdo_o, spi_sdo_oe_n_o, restart_o, shared_pin_o;
  dmc_pkg::dmc_mode_t mode_o, em;
  dmc_pkg::dmc_chan_t chan_i_o, chan_q_o;
  int err_total = 0;
  int cmp_count = 0;
  int restarts = 0;
  int sdio_lo = 0;
  int sdo_lo = 0;
  logic [7:0] rv;
  // Read-back of all ones per address 01h..0Eh.
  logic [7:0] msk [1:14] = '{8'hFF, 8'hF7, 8'h83, 8'hC7, 8'hFF, 8'h0F, 8'hFF, 8'h83, 8'hFF, 8'h0F, 8'hFF,
    8'h83, {4'h0, VER}, 8'h00};

  // The shared data line goes to whoever enables it.
  assign spi_sdio_i = spi_sdio_oe_n_o ? h_sdio : spi_sdio_o;
  assign rd_bit = spi_sdo_oe_n_o ? spi_sdio_i : spi_sdo_o;

  dmc_regs #(.VERSION(VER)) i_dmc_regs (.clk_i, .srst_i, .spi_sclk_i, .spi_cs_n_i, .spi_sdio_i, .spi_sdio_o,
    .spi_sdio_oe_n_o, .spi_sdo_o, .spi_sdo_oe_n_o, .pll_lock_i, .rate_clk_i, .mode_o, .chan_i_o, .chan_q_o,
    .restart_o, .shared_pin_o);
  dmc_spi_host i_dmc_spi_host (.clk_i, .rd_i(rd_bit), .sclk_o(spi_sclk_i), .cs_n_o(spi_cs_n_i), .sdio_o(h_sdio));

  initial forever #25 clk_i = ~clk_i;
  always @(posedge clk_i) rate_clk_i <= ~rate_clk_i;
  // Pulses are counted off the edge to avoid racing the register.
  always @(negedge clk_i) if (restart_o === 1'b1) restarts++;
  // Cycles in which the device enables the data pin or the separate output pin.
  always @(negedge clk_i) begin
    if (spi_sdio_oe_n_o === 1'b0) sdio_lo++;
    if (spi_sdo_oe_n_o === 1'b0) sdo_lo++;
  end

  task automatic check(input string what, input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      err_total++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    i_dmc_spi_host.xfer({3'h0, a[4:0]}, d, lsb, rv);
  endtask

  task automatic rdc(input logic [7:0] a, input logic [7:0] exp);
    i_dmc_spi_host.xfer(8'h80 | a, 8'h00, lsb, rv);
    check($sformatf("reg %h", a), rv, exp);
  endtask

  task automatic summarize();
    $display("Checks %0d errors %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  // A hang counts as a mismatch.
  initial begin
    repeat (90000) @(posedge clk_i);
    err_total++;
    summarize();
  end

  initial begin
    repeat (20) @(posedge clk_i);
    srst_i <= 1'b0;
    repeat (8) @(negedge clk_i);
    em = '0;
    em.real_mix = 1'b1;
    check("mode", mode_o, em);
    for (int a = 0; a < 14; a++) rdc(a, a == 1 ? 8'h04 : a == 13 ? {4'h0, VER} : 8'h00);
    check("sdio oe", sdio_lo, 0);
    check("sdo oe", sdo_lo > 0, 1);
    for (int a = 1; a < 15; a++) begin
      wr(a, 8'hFF);
      rdc(a, msk[a]);
    end
    // An address above the bank must not alias onto a low register.
    wr(8'h15, 8'h00);
    rdc(8'h05, 8'hFF);
    for (int k = 0; k < 4; k++) begin
      wr(8'h01, {k[1:0], k[1:0], k[0], 3'h0});
      check("interp", mode_o.interp, k);
      check("mod", mode_o.modulation, k);
      check("stuff", mode_o.zero_stuff, k[0]);
    end
    wr(8'h01, 8'h01);
    repeat (2) @(negedge clk_i) check("pin clk", shared_pin_o, rate_clk_i);
    wr(8'h01, 8'h00);
    pll_lock_i <= 1'b1;
    repeat (12) @(negedge clk_i);
    check("pin lock", shared_pin_o, 1);
    wr(8'h07, 8'h96);
    wr(8'h08, 8'h02);
    wr(8'h0B, 8'h5A);
    wr(8'h0C, 8'h81);
    check("i off", chan_i_o.offset, 10'h25A);
    check("i dir", chan_i_o.offset_on_comp, 0);
    check("q off", chan_q_o.offset, 10'h169);
    check("q dir", chan_q_o.offset_on_comp, 1);
    check("gains", {chan_i_o.fine_gain, chan_i_o.coarse_gain, chan_q_o.fine_gain, chan_q_o.coarse_gain}, 24'hFFFFFF);
    wr(8'h00, 8'hE0);
    lsb = 1'b1;
    sdo_lo = 0;
    check("restart", restarts, 1);
    rdc(8'h00, 8'hC2);
    rdc(8'h01, 8'h04);
    rdc(8'h07, 8'h00);
    check("sdo oe bidir", sdo_lo, 0);
    check("sdio oe bidir", sdio_lo > 0, 1);
    wr(8'h05, 8'h12);
    check("lsb write", chan_i_o.fine_gain, 8'h12);
    @(posedge clk_i);
    srst_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    srst_i <= 1'b0;
    lsb = 1'b0;
    repeat (8) @(posedge clk_i);
    rdc(8'h00, 8'h02);
    summarize();
  end
endmodule

`default_nettype wire
